// ### pbio_regs.svh
// Register offsets, reset values and field positions of the eight-bit port
`ifndef PBIO_REGS_SVH
`define PBIO_REGS_SVH
`define PBIO_OFF_OUTPUT_LATCH 16'h0000
`define PBIO_OFF_DRIVE_TYPE 16'h000B
`define PBIO_OFF_PIN_LEVEL 16'h000C
`define PBIO_OFF_FUNC_MODE 16'h0010
`define PBIO_BYTE_ADDR(idx) ({(idx), 2'b00})
`define PBIO_RST_OUTPUT_LATCH 8'hFF
`define PBIO_RST_DRIVE_TYPE 8'h00
`define PBIO_RST_FUNC_MODE 1'b0
`define PBIO_BIT_UART_TX 0
`define PBIO_BIT_UART_RX 1
`define PBIO_BIT_PROG_RX 2
`define PBIO_BIT_PROG_TX 3
`define PBIO_ADDR_W 18
`endif

// ### pbio_pkg.sv
// Types shared by the eight-bit port design
package pbio_pkg;
  typedef enum logic [2:0] {
    PBIO_IDLE = 3'b001,
    PBIO_WDONE = 3'b010,
    PBIO_RDONE = 3'b100
  } pbio_bus_state_t;
  typedef enum logic [0:0] {
    PBIO_MODE_RUN = 1'b0,
    PBIO_MODE_PROG = 1'b1
  } pbio_func_mode_t;
endpackage

// ### pbio_pad_bit.sv
// One port bit: output stage select and pin sampling
`timescale 1ns/1ps
module pbio_pad_bit (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic latch_bit,
  input wire logic push_pull,
  input wire logic sample_en,
  input wire logic pin_i,
  output logic pin_o,
  output logic pin_oe_n,
  output logic sampled_r
);
  // Zero latch drives low always; one drives high only when push-pull, else floats
  always_comb begin
    pin_o = latch_bit;
    pin_oe_n = ~(push_pull | ~latch_bit);
  end

  // No input latch: live pin value taken only at the read sample moment
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sampled_r <= 1'b0;
    end else if (sample_en) begin
      sampled_r <= pin_i;
    end
  end
endmodule

// ### pbio_port.sv
// Eight-bit bidirectional port with AXI4-Lite register access
`timescale 1ns/1ps
`include "pbio_regs.svh"
module pbio_port #(
  parameter int WIDTH = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`PBIO_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`PBIO_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] pin_o,
  output logic [WIDTH-1:0] pin_oe_n,
  output logic uart_txd_i,
  input wire logic uart_txd_o,
  input wire logic uart_txd_en,
  output logic uart_rxd,
  output logic func_mode
);
  localparam logic [`PBIO_ADDR_W-1:0] A_LATCH = `PBIO_BYTE_ADDR(`PBIO_OFF_OUTPUT_LATCH);
  localparam logic [`PBIO_ADDR_W-1:0] A_DRIVE = `PBIO_BYTE_ADDR(`PBIO_OFF_DRIVE_TYPE);
  localparam logic [`PBIO_ADDR_W-1:0] A_PIN = `PBIO_BYTE_ADDR(`PBIO_OFF_PIN_LEVEL);
  localparam logic [`PBIO_ADDR_W-1:0] A_MODE = `PBIO_BYTE_ADDR(`PBIO_OFF_FUNC_MODE);

  pbio_pkg::pbio_bus_state_t wst_r;
  pbio_pkg::pbio_bus_state_t rst_r;
  logic [WIDTH-1:0] output_latch_r;
  logic [WIDTH-1:0] drive_type_r;
  logic [WIDTH-1:0] pin_sampled;
  logic [WIDTH-1:0] drive_bits;
  logic [WIDTH-1:0] latch_bits;
  pbio_pkg::pbio_func_mode_t mode_r;
  logic aw_held_r;
  logic w_held_r;
  logic [`PBIO_ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic [`PBIO_ADDR_W-1:0] araddr_r;
  logic wr_fire;
  logic rd_sample;
  logic [`PBIO_ADDR_W-1:0] wa;
  logic [31:0] wd;
  logic [3:0] ws;

  // Write address and data taken in either order, held until both present
  assign s_axi_awready = (wst_r == pbio_pkg::PBIO_IDLE) && !aw_held_r;
  assign s_axi_wready = (wst_r == pbio_pkg::PBIO_IDLE) && !w_held_r;
  assign s_axi_arready = (rst_r == pbio_pkg::PBIO_IDLE);
  assign s_axi_bvalid = (wst_r == pbio_pkg::PBIO_WDONE);
  assign s_axi_bresp = 2'b00;
  assign s_axi_rvalid = (rst_r == pbio_pkg::PBIO_RDONE);
  assign s_axi_rresp = 2'b00;

  always_comb begin
    wa = aw_held_r ? awaddr_r : s_axi_awaddr;
    wd = w_held_r ? wdata_r : s_axi_wdata;
    ws = w_held_r ? wstrb_r : s_axi_wstrb;
    wr_fire = (wst_r == pbio_pkg::PBIO_IDLE) && (aw_held_r || s_axi_awvalid) && (w_held_r || s_axi_wvalid);
    rd_sample = s_axi_arvalid && s_axi_arready;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else if (wr_fire) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wst_r <= pbio_pkg::PBIO_IDLE;
    end else begin
      case (wst_r)
        pbio_pkg::PBIO_IDLE: begin
          if (wr_fire) begin
            wst_r <= pbio_pkg::PBIO_WDONE;
          end
        end
        pbio_pkg::PBIO_WDONE: begin
          if (s_axi_bready) begin
            wst_r <= pbio_pkg::PBIO_IDLE;
          end
        end
        default: wst_r <= pbio_pkg::PBIO_IDLE;
      endcase
    end
  end

  // Register update on the same edge that takes the write, as the bus leaves its first state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      output_latch_r <= WIDTH'(`PBIO_RST_OUTPUT_LATCH);
      drive_type_r <= WIDTH'(`PBIO_RST_DRIVE_TYPE);
      mode_r <= pbio_pkg::pbio_func_mode_t'(`PBIO_RST_FUNC_MODE);
    end else if (wr_fire && ws[0]) begin
      if (wa[`PBIO_ADDR_W-1:2] == A_LATCH[`PBIO_ADDR_W-1:2]) begin
        output_latch_r <= wd[WIDTH-1:0];
      end
      if (wa[`PBIO_ADDR_W-1:2] == A_DRIVE[`PBIO_ADDR_W-1:2]) begin
        drive_type_r <= wd[WIDTH-1:0];
      end
      if (wa[`PBIO_ADDR_W-1:2] == A_MODE[`PBIO_ADDR_W-1:2]) begin
        mode_r <= pbio_pkg::pbio_func_mode_t'(wd[0]);
      end
      // Pin level address falls through untouched
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_r <= pbio_pkg::PBIO_IDLE;
      araddr_r <= '0;
    end else begin
      case (rst_r)
        pbio_pkg::PBIO_IDLE: begin
          if (rd_sample) begin
            rst_r <= pbio_pkg::PBIO_RDONE;
            araddr_r <= s_axi_araddr;
          end
        end
        pbio_pkg::PBIO_RDONE: begin
          if (s_axi_rready) begin
            rst_r <= pbio_pkg::PBIO_IDLE;
          end
        end
        default: rst_r <= pbio_pkg::PBIO_IDLE;
      endcase
    end
  end

  // Read data are muxed from registers; pin value is the one sampled at address accept
  always_comb begin
    s_axi_rdata = 32'h0000_0000;
    if (rst_r == pbio_pkg::PBIO_RDONE) begin
      if (araddr_r[`PBIO_ADDR_W-1:2] == A_LATCH[`PBIO_ADDR_W-1:2]) begin
        s_axi_rdata[WIDTH-1:0] = output_latch_r;
      end else if (araddr_r[`PBIO_ADDR_W-1:2] == A_DRIVE[`PBIO_ADDR_W-1:2]) begin
        s_axi_rdata[WIDTH-1:0] = drive_type_r;
      end else if (araddr_r[`PBIO_ADDR_W-1:2] == A_PIN[`PBIO_ADDR_W-1:2]) begin
        s_axi_rdata[WIDTH-1:0] = pin_sampled;
      end else if (araddr_r[`PBIO_ADDR_W-1:2] == A_MODE[`PBIO_ADDR_W-1:2]) begin
        s_axi_rdata[0] = mode_r;
      end
    end
  end

  // Transmit function ANDs the UART output into its pin's latch bit while enabled
  always_comb begin
    latch_bits = output_latch_r;
    drive_bits = drive_type_r;
    if (uart_txd_en) begin
      if (mode_r == pbio_pkg::PBIO_MODE_RUN) begin
        latch_bits[`PBIO_BIT_UART_TX] = output_latch_r[`PBIO_BIT_UART_TX] & uart_txd_o;
      end else begin
        latch_bits[`PBIO_BIT_PROG_TX] = output_latch_r[`PBIO_BIT_PROG_TX] & uart_txd_o;
      end
    end
  end

  // Receive path taken live; function needs its latch bit at one
  always_comb begin
    uart_rxd = (mode_r == pbio_pkg::PBIO_MODE_RUN) ? pin_i[`PBIO_BIT_UART_RX] : pin_i[`PBIO_BIT_PROG_RX];
    uart_txd_i = (mode_r == pbio_pkg::PBIO_MODE_RUN) ? pin_i[`PBIO_BIT_UART_TX] : pin_i[`PBIO_BIT_PROG_TX];
    func_mode = mode_r;
  end

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      pbio_pad_bit u_bit (
        .aclk(aclk),
        .aresetn(aresetn),
        .latch_bit(latch_bits[gi]),
        .push_pull(drive_bits[gi]),
        .sample_en(rd_sample),
        .pin_i(pin_i[gi]),
        .pin_o(pin_o[gi]),
        .pin_oe_n(pin_oe_n[gi]),
        .sampled_r(pin_sampled[gi])
      );
    end
  endgenerate
endmodule

// ### pbio_pins_model.sv
// External circuit on the port pins
`timescale 1ns/1ps
module pbio_pins_model (
  input wire logic [7:0] pin_o,
  input wire logic [7:0] pin_oe_n,
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  output logic [7:0] pin_i
);
  // Pull-ups on every line; a low driver wins (wired-AND)
  assign pin_i = (pin_oe_n | pin_o) & (~ext_en | ext_val);
endmodule

// ### pbio_port_chk.sv
// Assertions on the port bus and pins
`timescale 1ns/1ps
`include "pbio_regs.svh"
module pbio_port_chk #(
  parameter int WIDTH = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`PBIO_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [`PBIO_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic [WIDTH-1:0] pin_i,
  input wire logic [WIDTH-1:0] pin_o,
  input wire logic [WIDTH-1:0] pin_oe_n,
  input wire logic uart_rxd,
  input wire logic func_mode
);
  localparam logic [`PBIO_ADDR_W-1:0] LA = `PBIO_BYTE_ADDR(`PBIO_OFF_OUTPUT_LATCH);
  localparam logic [`PBIO_ADDR_W-1:0] PA = `PBIO_BYTE_ADDR(`PBIO_OFF_PIN_LEVEL);
  // Bench offers address and data together
  wire wa = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire ra = s_axi_arvalid && s_axi_arready;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_write_resp: assert property (wa |=> s_axi_bvalid)
    else $error("write response late");
  a_latch_drive: assert property (wa && s_axi_wstrb[0] && s_axi_awaddr == LA |=>
    pin_o == $past(s_axi_wdata[7:0]))
    else $error("pins not updated");
  a_read_resp: assert property (ra |=> s_axi_rvalid)
    else $error("read response late");
  a_pin_sample: assert property (ra && s_axi_araddr == PA |=> s_axi_rdata[7:0] == $past(pin_i))
    else $error("pin read wrong");
  a_latch_read: assert property (ra && s_axi_araddr == LA |=> s_axi_rdata[7:0] == pin_o)
    else $error("latch read wrong");
  a_ro_ignored: assert property (wa && s_axi_awaddr == PA |=> $stable(pin_o) && $stable(pin_oe_n))
    else $error("pin level write acted");
  a_od_float: assert property ((pin_oe_n & ~pin_o) == '0)
    else $error("released pin with latch zero");
  a_reset_vals: assert property (disable iff (1'b0) !aresetn |=> pin_o == '1 && pin_oe_n == '1)
    else $error("reset values wrong");
  a_rx_select: assert property (uart_rxd == (func_mode ? pin_i[`PBIO_BIT_PROG_RX] : pin_i[`PBIO_BIT_UART_RX]))
    else $error("receive pin wrong");
  c_pin_read: cover property (ra && s_axi_araddr == PA);
  c_ro_write: cover property (wa && s_axi_awaddr == PA);
  c_prog_mode: cover property (func_mode);
endmodule
bind pbio_port pbio_port_chk #(.WIDTH(WIDTH)) u_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .pin_i(pin_i),
  .pin_o(pin_o), .pin_oe_n(pin_oe_n), .uart_rxd(uart_rxd), .func_mode(func_mode));

// ### pbio_port_tb_top.sv
// Self-checking bench for the eight-bit port
`timescale 1ns/1ps
`include "pbio_regs.svh"
module pbio_port_tb_top;
  localparam logic [17:0] LA = `PBIO_BYTE_ADDR(`PBIO_OFF_OUTPUT_LATCH);
  localparam logic [17:0] DA = `PBIO_BYTE_ADDR(`PBIO_OFF_DRIVE_TYPE);
  localparam logic [17:0] PA = `PBIO_BYTE_ADDR(`PBIO_OFF_PIN_LEVEL);
  localparam logic [17:0] MA = `PBIO_BYTE_ADDR(`PBIO_OFF_FUNC_MODE);
  logic aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, arv = 1'b0, rdy = 1'b0;
  logic txe = 1'b0, txo = 1'b0;
  wire [1:0] bresp, rresp;
  logic [17:0] awa = '0, ara = '0;
  logic [31:0] wd = '0;
  logic [3:0] ws = '0;
  logic [7:0] ext_en = '0, ext_val = '0, v;
  logic [31:0] expq[$];
  int fails = 0, checked = 0, seed = 51581;
  wire awr, wrr, bv, arr, rv, txd, rxd, fm;
  wire [31:0] rdata;
  wire [7:0] pin_i, pin_o, oe_n;
  always #5 aclk = ~aclk;
  pbio_port DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrr),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(rdy), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rdy), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_n(oe_n), .uart_txd_i(txd), .uart_txd_o(txo),
    .uart_txd_en(txe), .uart_rxd(rxd), .func_mode(fm));
  pbio_pins_model u_pins (.pin_o(pin_o), .pin_oe_n(oe_n), .ext_en(ext_en), .ext_val(ext_val), .pin_i(pin_i));
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    checked++;
    if (g !== x) begin
      fails++;
      $display("Error %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic end_of_test;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic tmo(input int n);
    if (n >= 50) begin
      fails++;
      end_of_test();
    end
  endtask
  // Responses are always accepted; ready stays high from reset release
  task automatic wr(input logic [17:0] a, input logic [7:0] d, input logic s);
    int n = 0;
    awa <= a;
    wd <= {$random(seed)} & 32'hFFFFFF00 | {24'h0, d};
    ws <= {3'h0, s};
    awv <= 1'b1;
    wv <= 1'b1;
    do begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wrr) wv <= 1'b0;
      n++;
    end while (!bv && n < 50);
    tmo(n);
  endtask
  task automatic rd(input logic [17:0] a, input logic [7:0] x);
    int n = 0;
    expq.push_back({24'h0, x});
    ara <= a;
    arv <= 1'b1;
    do begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
      n++;
    end while (!rv && n < 50);
    tmo(n);
  endtask
  // Result watcher: oldest expected read comes off the queue
  always @(posedge aclk) begin
    if (rv && rdy) begin
      chk("rdata", expq.pop_front(), rdata);
      chk("rresp", 32'h0, {30'h0, rresp});
    end
    if (bv && rdy) begin
      chk("bresp", 32'h0, {30'h0, bresp});
    end
  end
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rdy <= 1'b1;
    chk("oe_n", 32'hFF, {24'h0, oe_n});
    rd(LA, 8'hFF);
    rd(DA, 8'h00);
    rd(PA, 8'hFF);
    rd(MA, 8'h00);
    // Odd passes push-pull, even open-drain with random outside drivers
    for (int i = 0; i < 8; i++) begin
      v = 8'($random(seed));
      ext_val <= 8'($random(seed));
      ext_en <= i[0] ? 8'h00 : 8'($random(seed));
      wr(LA, 8'hFF, 1'b1);
      wr(DA, {8{i[0]}}, 1'b1);
      wr(LA, v, 1'b1);
      chk("pin_o", {24'h0, v}, {24'h0, pin_o});
      chk("oe_n", {24'h0, i[0] ? 8'h00 : v}, {24'h0, oe_n});
      wr(PA, ~v, 1'b1);
      wr(LA, ~v, 1'b0);
      rd(LA, v);
      rd(PA, i[0] ? v : v & (~ext_en | ext_val));
      ext_val <= ~ext_val;
      @(posedge aclk);
      rd(PA, i[0] ? v : v & (~ext_en | ext_val));
    end
    wr(DA, 8'hFF, 1'b1);
    wr(LA, 8'h05, 1'b1);
    wr(MA, 8'h01, 1'b1);
    chk("mode", 32'h1, {31'h0, fm});
    chk("rxd", 32'h1, {31'h0, rxd});
    chk("txd", 32'h0, {31'h0, txd});
    wr(MA, 8'h00, 1'b1);
    chk("rxd", 32'h0, {31'h0, rxd});
    chk("txd", 32'h1, {31'h0, txd});
    // Transmit function pulls bit 0 low only where its latch bit is one
    txe <= 1'b1;
    @(posedge aclk);
    chk("pin_o", 32'h04, {24'h0, pin_o});
    chk("txd", 32'h0, {31'h0, txd});
    txo <= 1'b1;
    @(posedge aclk);
    chk("pin_o", 32'h05, {24'h0, pin_o});
    txe <= 1'b0;
    // Mid-run reset restores latch, drive type and mode
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    chk("oe_n", 32'hFF, {24'h0, oe_n});
    rd(LA, 8'hFF);
    rd(DA, 8'h00);
    rd(MA, 8'h00);
    // Let the watcher finish the last compare before the verdict
    repeat (2) @(posedge aclk);
    end_of_test();
  end
endmodule
